// [include/sdc_pkg.sv]
// shared constants, field layouts and select decoding for the serial divider control block
package sdc_pkg;

    localparam int WORD_W    = 22;
    localparam int PIN_W     = 5;

    // pin bundle positions after synchronising
    localparam int PIN_SCLK  = 0;
    localparam int PIN_DATA  = 1;
    localparam int PIN_LOAD  = 2;
    localparam int PIN_IFLK  = 3;
    localparam int PIN_RFLK  = 4;

    // latch select codes in bits 1:0 of a word
    localparam logic [1:0] SEL_IF_REF = 2'h0;
    localparam logic [1:0] SEL_IF_FB  = 2'h1;
    localparam logic [1:0] SEL_RF_REF = 2'h2;
    localparam logic [1:0] SEL_RF_FB  = 2'h3;
    localparam int         SEL_MSB    = 1;

    // reference latch fields
    localparam int OSEL_HI_BIT = 21;
    localparam int OSEL_LO_BIT = 20;
    localparam int TRI_BIT     = 19;
    localparam int GAIN_BIT    = 18;
    localparam int POL_BIT     = 17;
    localparam int RDIV_MSB    = 15;
    localparam int RDIV_LSB    = 2;
    localparam int RDIV_W      = 14;

    // feedback latch fields
    localparam int PD_BIT      = 21;
    localparam int PSC_BIT     = 20;
    localparam int MAIN_MSB    = 19;
    localparam int MAIN_LSB    = 9;
    localparam int MAIN_W      = 11;
    localparam int SWAL_MSB    = 7;
    localparam int SWAL_LSB    = 2;
    localparam int SWAL_W      = 6;

    // prescaler modulus P (P/P+1) per select bit value
    localparam int         PSC_W       = 7;
    localparam logic [6:0] IF_PSC_ZERO = 7'h08;
    localparam logic [6:0] IF_PSC_ONE  = 7'h10;
    localparam logic [6:0] RF_PSC_ZERO = 7'h40;
    localparam logic [6:0] RF_PSC_ONE  = 7'h20;

    localparam logic [21:0] LATCH_RST  = 22'h000000;

    // output select codes, {rf_hi, rf_lo, if_hi, if_lo}
    localparam logic [3:0] MSEL_IF_LOCK   = 4'h1;
    localparam logic [3:0] MSEL_IF_CRST   = 4'h2;
    localparam logic [3:0] MSEL_RF_LOCK   = 4'h4;
    localparam logic [3:0] MSEL_BOTH_LOCK = 4'h5;
    localparam logic [3:0] MSEL_RF_CRST   = 4'h8;
    localparam logic [3:0] MSEL_BOTH_CRST = 4'ha;

    typedef enum logic [2:0] {
        MUX_HIZ,
        MUX_IF_LOCK,
        MUX_RF_LOCK,
        MUX_BOTH_LOCK,
        MUX_IF_CRST,
        MUX_RF_CRST,
        MUX_BOTH_CRST
    } sdc_mux_mode_t;

    function automatic sdc_mux_mode_t sdc_mux_decode(input logic [3:0] sel);
        case (sel)
            MSEL_IF_LOCK:   return MUX_IF_LOCK;
            MSEL_RF_LOCK:   return MUX_RF_LOCK;
            MSEL_BOTH_LOCK: return MUX_BOTH_LOCK;
            MSEL_IF_CRST:   return MUX_IF_CRST;
            MSEL_RF_CRST:   return MUX_RF_CRST;
            MSEL_BOTH_CRST: return MUX_BOTH_CRST;
            default:        return MUX_HIZ;
        endcase
    endfunction : sdc_mux_decode

    // charge pump drain time before a synchronous power-down completes
    localparam int         CLK_PERIOD_NS = 10;
    localparam int         PD_DRAIN_NS   = 100;
    localparam int         DRAIN_W       = 4;
    localparam logic [3:0] PD_DRAIN_CYC  =
        DRAIN_W'((PD_DRAIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage : sdc_pkg

// [hdl/sdc_pin_sync.sv]
// two-stage synchroniser with rising edge detect for the serial pins
`timescale 1ns/1ps
module sdc_pin_sync
    import sdc_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic [PIN_W-1:0] d_i,
    output logic      [PIN_W-1:0] q_o,
    output logic      [PIN_W-1:0] rise_o
);

    typedef struct packed {
        logic [PIN_W-1:0] meta;
        logic [PIN_W-1:0] sync;
        logic [PIN_W-1:0] prev;
    } sdc_sync_st_t;

    sdc_sync_st_t st_r;
    sdc_sync_st_t st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.meta = d_i;
        st_nxt.sync = st_r.meta;
        st_nxt.prev = st_r.sync;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // edges come from the second and third stages only
    assign q_o    = st_r.sync;
    assign rise_o = st_r.sync & ~st_r.prev;

endmodule : sdc_pin_sync

// [hdl/sdc_loop_pwr.sv]
// per-loop power-down sequencer and divider hold control
`timescale 1ns/1ps
module sdc_loop_pwr
    import sdc_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic pd_i,
    input  wire logic tristate_i,
    input  wire logic crst_i,
    output logic      pump_hiz_o,
    output logic      div_load_o,
    output logic      debias_o,
    output logic      down_o
);

    typedef enum logic [1:0] {
        ST_UP,
        ST_DRAIN,
        ST_DOWN
    } sdc_pwr_state_t;

    typedef struct packed {
        sdc_pwr_state_t     state;
        logic [DRAIN_W-1:0] cnt;
        logic               pump_hiz;
        logic               div_load;
        logic               down;
    } sdc_pwr_st_t;

    sdc_pwr_st_t st_r;
    sdc_pwr_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        case (st_r.state)
            ST_UP: begin
                if (pd_i) begin
                    if (tristate_i) begin
                        st_nxt.state = ST_DOWN;
                    end else begin
                        st_nxt.state = ST_DRAIN;
                        st_nxt.cnt   = PD_DRAIN_CYC - 4'h1;
                    end
                end
            end
            ST_DRAIN: begin
                if (!pd_i) begin
                    st_nxt.state = ST_UP;
                end else if (st_r.cnt == '0) begin
                    st_nxt.state = ST_DOWN;
                end else begin
                    st_nxt.cnt = st_r.cnt - 4'h1;
                end
            end
            ST_DOWN: begin
                if (!pd_i) begin
                    st_nxt.state = ST_UP;
                end
            end
            default: st_nxt.state = ST_UP;
        endcase
        st_nxt.pump_hiz = tristate_i | crst_i | (st_nxt.state != ST_UP);
        st_nxt.div_load = crst_i | (st_nxt.state == ST_DOWN);
        st_nxt.down     = (st_nxt.state == ST_DOWN);
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= '{state: ST_UP, cnt: '0, pump_hiz: 1'b0, div_load: 1'b0, down: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // one flop releases both dividers together
    assign div_load_o = st_r.div_load;
    assign pump_hiz_o = st_r.pump_hiz;
    assign debias_o   = st_r.down;
    assign down_o     = st_r.down;

    default clocking pwr_cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sync_pump_first_a: assert property (
        (st_r.state == ST_UP && pd_i && !tristate_i) |=> (pump_hiz_o && !down_o)[*2]
    ) else $error("synchronous power-down did not float pump first");

    async_down_a: assert property (
        (st_r.state == ST_UP && pd_i && tristate_i) |=> down_o && div_load_o
    ) else $error("asynchronous power-down not immediate");

    release_up_a: assert property (
        !pd_i |=> !down_o
    ) else $error("loop stayed down after power-down bit cleared");

    down_parks_a: assert property (
        down_o |-> div_load_o && debias_o && pump_hiz_o
    ) else $error("power-down without divider load or debias");

endmodule : sdc_loop_pwr

// [hdl/sdc_serial_latches.sv]
`timescale 1ns/1ps
module sdc_serial_latches
    import sdc_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              nrst_i,
    input  wire logic              ser_clk_i,
    input  wire logic              ser_data_i,
    input  wire logic              load_strobe_i,
    input  wire logic              if_lock_i,
    input  wire logic              rf_lock_i,
    input  wire logic              test_select_output_i,
    output logic                   test_select_output_o,
    output logic                   test_select_output_oe_o,
    output logic [RDIV_W-1:0]      if_ref_div_o,
    output logic                   if_detector_polarity_o,
    output logic                   if_pump_gain_o,
    output logic [MAIN_W-1:0]      if_main_cnt_o,
    output logic [SWAL_W-1:0]      if_swallow_cnt_o,
    output logic [PSC_W-1:0]       if_modulus_o,
    output logic                   if_pump_hiz_o,
    output logic                   if_div_load_o,
    output logic                   if_input_debias_o,
    output logic                   if_powered_down_o,
    output logic [RDIV_W-1:0]      rf_ref_div_o,
    output logic                   rf_detector_polarity_o,
    output logic                   rf_pump_gain_o,
    output logic [MAIN_W-1:0]      rf_main_cnt_o,
    output logic [SWAL_W-1:0]      rf_swallow_cnt_o,
    output logic [PSC_W-1:0]       rf_modulus_o,
    output logic                   rf_pump_hiz_o,
    output logic                   rf_div_load_o,
    output logic                   rf_input_debias_o,
    output logic                   rf_powered_down_o,
    output logic                   reference_input_off_o
);

    typedef struct packed {
        logic [WORD_W-1:0] shift;
        logic [WORD_W-1:0] if_ref;
        logic [WORD_W-1:0] if_fb;
        logic [WORD_W-1:0] rf_ref;
        logic [WORD_W-1:0] rf_fb;
        logic [PSC_W-1:0]  if_mod;
        logic [PSC_W-1:0]  rf_mod;
        logic              if_crst;
        logic              rf_crst;
        logic              pull_low;
        logic              osc_off;
    } sdc_top_st_t;

    sdc_top_st_t       st_r;
    sdc_top_st_t       st_nxt;
    logic [PIN_W-1:0]  pin_q;
    logic [PIN_W-1:0]  pin_rise;
    logic              sclk_rise;
    logic              load_rise;
    logic              sdata;
    logic              if_locked;
    logic              rf_locked;
    logic [WORD_W-2:0] shift_low;
    sdc_mux_mode_t     mux_mode;

    // all pins cross into clk_i through two flops before use
    sdc_pin_sync u_pin_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    ({rf_lock_i, if_lock_i, load_strobe_i, ser_data_i, ser_clk_i}),
        .q_o    (pin_q),
        .rise_o (pin_rise)
    );

    assign sclk_rise = pin_rise[PIN_SCLK];
    assign load_rise = pin_rise[PIN_LOAD];
    assign sdata     = pin_q[PIN_DATA];
    assign if_locked = pin_q[PIN_IFLK];
    assign rf_locked = pin_q[PIN_RFLK];
    assign shift_low = st_r.shift[WORD_W-2:0];

    // four select bits, two per reference latch
    assign mux_mode = sdc_mux_decode({st_r.rf_ref[OSEL_HI_BIT:OSEL_LO_BIT],
                                      st_r.if_ref[OSEL_HI_BIT:OSEL_LO_BIT]});

    always_comb begin
        st_nxt = st_r;

        // one bit per serial clock edge
        // msb first, older bits move up
        // bits beyond 22 fall off the top
        if (sclk_rise) begin
            st_nxt.shift = {shift_low, sdata};
        end

        // strobe copies word into one latch
        if (load_rise) begin
            case (st_r.shift[SEL_MSB:0])
                SEL_IF_REF: st_nxt.if_ref = st_r.shift;
                SEL_IF_FB: begin
                    st_nxt.if_fb  = st_r.shift;
                    st_nxt.if_mod = st_r.shift[PSC_BIT] ? IF_PSC_ONE : IF_PSC_ZERO;
                end
                SEL_RF_REF: st_nxt.rf_ref = st_r.shift;
                SEL_RF_FB: begin
                    st_nxt.rf_fb  = st_r.shift;
                    st_nxt.rf_mod = st_r.shift[PSC_BIT] ? RF_PSC_ONE : RF_PSC_ZERO;
                end
                default: st_nxt.shift = st_r.shift;
            endcase
        end

        st_nxt.if_crst = (mux_mode == MUX_IF_CRST) || (mux_mode == MUX_BOTH_CRST);
        st_nxt.rf_crst = (mux_mode == MUX_RF_CRST) || (mux_mode == MUX_BOTH_CRST);

        // oscillator off only with both sides down
        st_nxt.osc_off = st_r.if_fb[PD_BIT] & st_r.rf_fb[PD_BIT];

        // fast lock overrides any selected source
        if (st_r.rf_ref[GAIN_BIT]) begin
            st_nxt.pull_low = 1'b1;
        end else begin
            case (mux_mode)
                // released when locked, pulses pass through
                MUX_IF_LOCK:   st_nxt.pull_low = ~if_locked;
                MUX_RF_LOCK:   st_nxt.pull_low = ~rf_locked;
                MUX_BOTH_LOCK: st_nxt.pull_low = ~(if_locked & rf_locked);
                default:       st_nxt.pull_low = 1'b0;
            endcase
        end
    end

    // latch contents have no documented reset; zero keeps both loops powered
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= '{shift: LATCH_RST, if_ref: LATCH_RST, if_fb: LATCH_RST,
                      rf_ref: LATCH_RST, rf_fb: LATCH_RST, if_mod: IF_PSC_ZERO,
                      rf_mod: RF_PSC_ZERO, if_crst: 1'b0, rf_crst: 1'b0,
                      pull_low: 1'b0, osc_off: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // IF sequencing by pump float bit
    sdc_loop_pwr u_if_pwr (
        .clk_i      (clk_i),
        .nrst_i     (nrst_i),
        .pd_i       (st_r.if_fb[PD_BIT]),
        .tristate_i (st_r.if_ref[TRI_BIT]),
        .crst_i     (st_r.if_crst),
        .pump_hiz_o (if_pump_hiz_o),
        .div_load_o (if_div_load_o),
        .debias_o   (if_input_debias_o),
        .down_o     (if_powered_down_o)
    );

    // RF pair acts like the IF pair
    sdc_loop_pwr u_rf_pwr (
        .clk_i      (clk_i),
        .nrst_i     (nrst_i),
        .pd_i       (st_r.rf_fb[PD_BIT]),
        .tristate_i (st_r.rf_ref[TRI_BIT]),
        .crst_i     (st_r.rf_crst),
        .pump_hiz_o (rf_pump_hiz_o),
        .div_load_o (rf_div_load_o),
        .debias_o   (rf_input_debias_o),
        .down_o     (rf_powered_down_o)
    );

    // open drain: only ever pulls low, the external pull-up gives the high
    assign test_select_output_o    = 1'b0;
    assign test_select_output_oe_o = st_r.pull_low;

    assign if_ref_div_o           = st_r.if_ref[RDIV_MSB:RDIV_LSB];
    assign if_detector_polarity_o = st_r.if_ref[POL_BIT];
    assign if_pump_gain_o         = st_r.if_ref[GAIN_BIT];
    assign if_main_cnt_o          = st_r.if_fb[MAIN_MSB:MAIN_LSB];
    assign if_swallow_cnt_o       = st_r.if_fb[SWAL_MSB:SWAL_LSB];
    assign if_modulus_o           = st_r.if_mod;
    assign rf_ref_div_o           = st_r.rf_ref[RDIV_MSB:RDIV_LSB];
    assign rf_detector_polarity_o = st_r.rf_ref[POL_BIT];
    assign rf_pump_gain_o         = st_r.rf_ref[GAIN_BIT];
    assign rf_main_cnt_o          = st_r.rf_fb[MAIN_MSB:MAIN_LSB];
    assign rf_swallow_cnt_o       = st_r.rf_fb[SWAL_MSB:SWAL_LSB];
    assign rf_modulus_o           = st_r.rf_mod;
    assign reference_input_off_o  = st_r.osc_off;

    default clocking top_cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    shift_in_a: assert property (
        sclk_rise |=> st_r.shift == {$past(shift_low), $past(sdata)}
    ) else $error("serial bit not shifted in at clock edge");

    shift_idle_a: assert property (
        !sclk_rise |=> $stable(st_r.shift)
    ) else $error("shift register moved without serial clock edge");

    if_ref_load_a: assert property (
        (load_rise && st_r.shift[SEL_MSB:0] == SEL_IF_REF)
            |=> st_r.if_ref == $past(st_r.shift) && $stable(st_r.if_fb)
                && $stable(st_r.rf_ref) && $stable(st_r.rf_fb)
    ) else $error("IF reference latch load wrong");

    rf_fb_load_a: assert property (
        (load_rise && st_r.shift[SEL_MSB:0] == SEL_RF_FB)
            |=> st_r.rf_fb == $past(st_r.shift) && $stable(st_r.if_ref)
    ) else $error("RF feedback latch load wrong");

    latch_hold_a: assert property (
        !load_rise |=> $stable(st_r.if_ref) && $stable(st_r.if_fb)
                       && $stable(st_r.rf_ref) && $stable(st_r.rf_fb)
    ) else $error("latch changed without load strobe");

    if_modulus_a: assert property (
        (load_rise && st_r.shift[SEL_MSB:0] == SEL_IF_FB)
            |=> if_modulus_o == ($past(st_r.shift[PSC_BIT]) ? IF_PSC_ONE : IF_PSC_ZERO)
    ) else $error("IF prescaler modulus wrong");

    fast_lock_a: assert property (
        st_r.rf_ref[GAIN_BIT] |=> test_select_output_oe_o
    ) else $error("fast lock did not pull test output low");

    both_lock_a: assert property (
        (!st_r.rf_ref[GAIN_BIT] && mux_mode == MUX_BOTH_LOCK && !(if_locked && rf_locked))
            |=> test_select_output_oe_o
    ) else $error("combined lock shown without both loops locked");

    osc_off_a: assert property (
        (st_r.if_fb[PD_BIT] && st_r.rf_fb[PD_BIT]) |=> reference_input_off_o
    ) else $error("reference oscillator left on with both sides down");

    osc_on_a: assert property (
        !(st_r.if_fb[PD_BIT] && st_r.rf_fb[PD_BIT]) |=> !reference_input_off_o
    ) else $error("reference oscillator off with a side powered");

    crst_hold_a: assert property (
        st_r.if_crst |=> if_div_load_o && if_pump_hiz_o
    ) else $error("IF counter reset did not hold dividers");

    pd_latch_live_a: assert property (
        (if_powered_down_o && load_rise && st_r.shift[SEL_MSB:0] == SEL_RF_REF)
            |=> st_r.rf_ref == $past(st_r.shift)
    ) else $error("latching blocked during power-down");

endmodule : sdc_serial_latches

// [testbench/sdc_host_model.sv]
// host side of the three-wire programming link
`timescale 1ns/1ps
module sdc_host_model (
    input  wire logic clk_i,
    output logic      ser_clk_o,
    output logic      ser_data_o,
    output logic      load_o
);
    initial begin
        ser_clk_o  = 1'b0;
        ser_data_o = 1'b0;
        load_o     = 1'b0;
    end

    // two stale bits go ahead of the word when asked
    task automatic send(input logic [21:0] w, input logic pre);
        logic [23:0] s;
        int          n;
        s = {~w[21:20], w};
        n = pre ? 24 : 22;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk_i);
            ser_data_o <= s[i];
            repeat (8) @(posedge clk_i);
            ser_clk_o <= 1'b1;
            repeat (8) @(posedge clk_i);
            ser_clk_o <= 1'b0;
        end
        repeat (8) @(posedge clk_i);
        load_o <= 1'b1;
        repeat (8) @(posedge clk_i);
        load_o     <= 1'b0;
        // data line no longer meaningful between frames
        ser_data_o <= ~ser_data_o;
        repeat (4) @(posedge clk_i);
    endtask : send
endmodule : sdc_host_model

// [testbench/test_sdc_serial_latches.sv]
// self-checking bench for the serial divider control latches
`timescale 1ns/1ps
module test_sdc_serial_latches
    import sdc_pkg::*;
;
    logic clk_i;
    logic nrst_i;
    logic if_lock;
    logic rf_lock;
    logic sclk;
    logic sdat;
    logic load;
    logic pin_out;
    logic pin_oe;
    wire  pin;
    int   err_count = 0;
    int   cmp_count = 0;
    int   cyc = 0;

    sdc_host_model host (.clk_i(clk_i), .ser_clk_o(sclk), .ser_data_o(sdat), .load_o(load));

    sdc_serial_latches uut (
        .clk_i(clk_i), .nrst_i(nrst_i), .ser_clk_i(sclk), .ser_data_i(sdat),
        .load_strobe_i(load), .if_lock_i(if_lock), .rf_lock_i(rf_lock),
        .test_select_output_i(pin), .test_select_output_o(pin_out),
        .test_select_output_oe_o(pin_oe), .if_ref_div_o(), .if_detector_polarity_o(),
        .if_pump_gain_o(), .if_main_cnt_o(), .if_swallow_cnt_o(), .if_modulus_o(),
        .if_pump_hiz_o(), .if_div_load_o(), .if_input_debias_o(), .if_powered_down_o(),
        .rf_ref_div_o(), .rf_detector_polarity_o(), .rf_pump_gain_o(), .rf_main_cnt_o(),
        .rf_swallow_cnt_o(), .rf_modulus_o(), .rf_pump_hiz_o(), .rf_div_load_o(),
        .rf_input_debias_o(), .rf_powered_down_o(), .reference_input_off_o()
    );

    // open drain pin, external pull-up
    assign pin = pin_oe ? pin_out : 1'b1;

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic give_verdict();
        if (err_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        // callers sample right at a clock edge; g is copied at the call, before this delay
        #1;
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    function automatic logic [21:0] rw(input logic [1:0] os, input logic tri_b,
            input logic gain, input logic pol, input logic [13:0] rd, input logic [1:0] sel);
        return {os, tri_b, gain, pol, 1'b0, rd, sel};
    endfunction : rw

    function automatic logic [21:0] fw(input logic pd, input logic psc,
            input logic [10:0] mc, input logic [5:0] sw, input logic [1:0] sel);
        return {pd, psc, mc, 1'b0, sw, sel};
    endfunction : fw

    initial begin
        nrst_i  = 1'b0;
        if_lock = 1'b0;
        rf_lock = 1'b0;
        tick(5);
        nrst_i <= 1'b1;
        tick(3);
        chk("if_mod", 16'h8, 16'(uut.if_modulus_o));
        chk("rf_mod", 16'h40, 16'(uut.rf_modulus_o));
        host.send(rw(2'h0, 1'b0, 1'b1, 1'b1, 14'h1234, SEL_IF_REF), 1'b0);
        chk("if_rdiv", 16'h1234, 16'(uut.if_ref_div_o));
        chk("if_pol_gain", 16'h3, 16'({uut.if_detector_polarity_o, uut.if_pump_gain_o}));
        host.send(fw(1'b0, 1'b1, 11'h5a5, 6'h2a, SEL_IF_FB), 1'b1);
        chk("if_main", 16'h5a5, 16'(uut.if_main_cnt_o));
        chk("if_swal", 16'h2a, 16'(uut.if_swallow_cnt_o));
        chk("if_mod", 16'h10, 16'(uut.if_modulus_o));
        chk("if_rdiv", 16'h1234, 16'(uut.if_ref_div_o));
        host.send(rw(2'h0, 1'b0, 1'b0, 1'b1, 14'h3fff, SEL_RF_REF), 1'b0);
        chk("rf_rdiv", 16'h3fff, 16'(uut.rf_ref_div_o));
        chk("rf_pol", 16'h1, 16'(uut.rf_detector_polarity_o));
        host.send(fw(1'b0, 1'b1, 11'h7ff, 6'h01, SEL_RF_FB), 1'b0);
        chk("rf_main", 16'h7ff, 16'(uut.rf_main_cnt_o));
        chk("rf_swal", 16'h1, 16'(uut.rf_swallow_cnt_o));
        chk("rf_mod", 16'h20, 16'(uut.rf_modulus_o));
        host.send(rw(2'h2, 1'b0, 1'b0, 1'b0, 14'h1234, SEL_IF_REF), 1'b0);
        chk("crst", 16'h6, 16'({uut.if_div_load_o, uut.if_pump_hiz_o, uut.rf_div_load_o}));
        chk("crst_pin", 16'h1, 16'(pin));
        host.send(rw(2'h1, 1'b0, 1'b0, 1'b0, 14'h1234, SEL_IF_REF), 1'b0);
        chk("unlock_pin", 16'h0, 16'(pin));
        if_lock <= 1'b1;
        tick(8);
        chk("lock_pin", 16'h1, 16'(pin));
        host.send(rw(2'h1, 1'b0, 1'b0, 1'b0, 14'h3fff, SEL_RF_REF), 1'b0);
        chk("both_pin", 16'h0, 16'(pin));
        rf_lock <= 1'b1;
        tick(8);
        chk("both_pin", 16'h1, 16'(pin));
        host.send(rw(2'h1, 1'b0, 1'b1, 1'b0, 14'h3fff, SEL_RF_REF), 1'b0);
        chk("fast_pin", 16'h0, 16'(pin));
        chk("rf_gain", 16'h1, 16'(uut.rf_pump_gain_o));
        host.send(rw(2'h0, 1'b1, 1'b0, 1'b0, 14'h1234, SEL_IF_REF), 1'b0);
        host.send(fw(1'b1, 1'b0, 11'h5a5, 6'h2a, SEL_IF_FB), 1'b0);
        chk("if_down", 16'h7, 16'({uut.if_powered_down_o, uut.if_input_debias_o,
            uut.if_div_load_o}));
        chk("osc_off", 16'h0, 16'(uut.reference_input_off_o));
        // pump must float well before the drain time runs out
        host.send(fw(1'b1, 1'b0, 11'h7ff, 6'h01, SEL_RF_FB), 1'b0);
        chk("rf_sync", 16'h2, 16'({uut.rf_pump_hiz_o, uut.rf_powered_down_o}));
        tick(20);
        chk("rf_down", 16'h7, 16'({uut.rf_powered_down_o, uut.rf_input_debias_o,
            uut.rf_div_load_o}));
        chk("osc_off", 16'h1, 16'(uut.reference_input_off_o));
        chk("rf_mod", 16'h40, 16'(uut.rf_modulus_o));
        host.send(rw(2'h0, 1'b0, 1'b0, 1'b0, 14'h0001, SEL_RF_REF), 1'b0);
        chk("rf_rdiv", 16'h1, 16'(uut.rf_ref_div_o));
        host.send(fw(1'b0, 1'b0, 11'h5a5, 6'h2a, SEL_IF_FB), 1'b0);
        chk("if_up", 16'h0, 16'({uut.if_powered_down_o, uut.if_div_load_o}));
        chk("osc_off", 16'h0, 16'(uut.reference_input_off_o));
        host.send(fw(1'b0, 1'b0, 11'h7ff, 6'h01, SEL_RF_FB), 1'b0);
        chk("rf_up", 16'h0, 16'({uut.rf_powered_down_o, uut.rf_div_load_o}));
        // RF lock source alone, IF select pair left at zero
        host.send(rw(2'h1, 1'b0, 1'b0, 1'b0, 14'h0001, SEL_RF_REF), 1'b0);
        chk("rf_lock_pin", 16'h1, 16'(pin));
        rf_lock <= 1'b0;
        tick(8);
        chk("rf_unlock_pin", 16'h0, 16'(pin));
        host.send(rw(2'h2, 1'b0, 1'b0, 1'b0, 14'h0001, SEL_RF_REF), 1'b0);
        chk("rf_crst", 16'h6, 16'({uut.rf_div_load_o, uut.rf_pump_hiz_o,
            uut.if_div_load_o}));
        host.send(rw(2'h2, 1'b1, 1'b0, 1'b0, 14'h1234, SEL_IF_REF), 1'b0);
        chk("both_crst", 16'h3, 16'({uut.if_div_load_o, uut.rf_div_load_o}));
        give_verdict();
    end
endmodule : test_sdc_serial_latches
